// [hw/boot_mode_selector.sv]
// Boot mode selection and bootstrap channel detection
`timescale 1ns/1ps
`default_nettype none
module boot_mode_selector (
  input  wire logic                          clock_in,
  input  wire logic                          rst_in,
  input  wire logic                          external_reset_input,
  input  wire logic                          boot_config_bit_high,
  input  wire logic                          boot_config_bit_low,
  input  wire logic                          uart_receive_line,
  input  wire logic                          can_receive_line,
  output logic                               flash_read_req_out,
  output logic [1:0]                         flash_read_addr_out,
  input  wire logic                          flash_read_valid_in,
  input  wire logic [15:0]                   flash_read_data_in,
  output boot_mode_pkg::boot_mode_t          boot_mode_out,
  output logic                               fetch_test_flash_out,
  output boot_mode_pkg::boot_channel_t       boot_channel_out,
  output logic                               software_reset_out,
  output logic                               run_user_code_out,
  output logic                               boot_hang_out,
  output logic                               boot_done_out
);
  import boot_mode_pkg::*;

  typedef enum logic [3:0] {
    ST_IN_RESET  = 4'h0,
    ST_DECODE    = 4'h1,
    ST_SCAN      = 4'h2,
    ST_READ_A    = 4'h3,
    ST_READ_B    = 4'h4,
    ST_CHECK     = 4'h5,
    ST_READ_KEY  = 4'h6,
    ST_KEY       = 4'h7,
    ST_DONE      = 4'h8,
    ST_HANG      = 4'h9
  } state_t;

  // Two-stage synchronisers for the reset, config, UART and CAN pins; flash read inputs are used unsynchronised
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= 5'h1F;
      sync2_q <= 5'h1F;
    end else begin
      sync1_q <= {external_reset_input, boot_config_bit_high, boot_config_bit_low,
                  uart_receive_line, can_receive_line};
      sync2_q <= sync1_q;
    end
  end

  logic ext_rst_s;
  logic cfg_high_s;
  logic cfg_low_s;
  logic uart_s;
  logic can_s;
  assign ext_rst_s  = sync2_q[4];
  assign cfg_high_s = sync2_q[3];
  assign cfg_low_s  = sync2_q[2];
  assign uart_s     = sync2_q[1];
  assign can_s      = sync2_q[0];

  state_t        state_q, state_d;
  logic          ext_rst_prev_q, ext_rst_prev_d;
  logic [1:0]    cfg_q, cfg_d;
  boot_mode_t    mode_q, mode_d;
  boot_channel_t chan_q, chan_d;
  logic [15:0]   sig_q, sig_d;
  logic [7:0]    can_cnt_q, can_cnt_d;
  logic          uart_en_q, uart_en_d;
  logic          can_en_q, can_en_d;
  logic          swrst_q, swrst_d;
  logic          run_q, run_d;
  logic          req_q, req_d;
  logic [1:0]    addr_q, addr_d;

  always_comb begin
    state_d        = state_q;
    ext_rst_prev_d = ext_rst_s;
    cfg_d          = cfg_q;
    mode_d         = mode_q;
    chan_d         = chan_q;
    sig_d          = sig_q;
    can_cnt_d      = can_cnt_q;
    uart_en_d      = uart_en_q;
    can_en_d       = can_en_q;
    swrst_d        = 1'b0;
    run_d          = run_q;
    req_d          = 1'b0;
    addr_d         = addr_q;
    if (!ext_rst_s) begin
      // External reset held low: state, mode, channel, run flag and CAN count return to the start
      state_d   = ST_IN_RESET;
      mode_d    = MODE_NONE;
      chan_d    = CHAN_NONE;
      run_d     = 1'b0;
      can_cnt_d = CNT_ZERO;
    end else begin
      unique case (state_q)
        ST_IN_RESET: begin
          if (!ext_rst_prev_q) begin
            cfg_d   = {cfg_high_s, cfg_low_s};
            state_d = ST_DECODE;
          end
        end
        ST_DECODE: begin
          uart_en_d = 1'b1;
          can_en_d  = 1'b1;
          unique case (cfg_q)
            CFG_USER: begin
              mode_d  = MODE_USER;
              run_d   = 1'b1;
              state_d = ST_DONE;
            end
            CFG_STANDARD: begin
              mode_d  = MODE_STANDARD;
              state_d = ST_SCAN;
            end
            CFG_SELECTIVE: begin
              mode_d  = MODE_SELECTIVE;
              req_d   = 1'b1;
              addr_d  = FLASH_ADDR_SIG_A;
              state_d = ST_READ_A;
            end
            CFG_RESERVED: begin
              mode_d  = MODE_RESERVED;
              state_d = ST_HANG;
            end
          endcase
        end
        ST_SCAN: begin
          // UART start bit seen first wins; CAN needs a full dominant bit time
          if (uart_en_q && !uart_s) begin
            chan_d  = CHAN_UART;
            state_d = ST_DONE;
          end else if (can_en_q && !can_s) begin
            can_cnt_d = can_cnt_q + CNT_ONE;
            if (can_cnt_q == CAN_BIT_CYCLES - CNT_ONE) begin
              chan_d  = CHAN_CAN;
              state_d = ST_DONE;
            end
          end else begin
            can_cnt_d = CNT_ZERO;
          end
        end
        ST_READ_A: begin
          if (flash_read_valid_in) begin
            sig_d   = flash_read_data_in;
            req_d   = 1'b1;
            addr_d  = FLASH_ADDR_SIG_B;
            state_d = ST_READ_B;
          end else begin
            req_d = 1'b1;
          end
        end
        ST_READ_B: begin
          if (flash_read_valid_in) begin
            sig_d   = sig_q ^ flash_read_data_in;
            state_d = ST_CHECK;
          end else begin
            req_d = 1'b1;
          end
        end
        ST_CHECK: begin
          if (sig_q == SIG_REFERENCE) begin
            swrst_d = 1'b1;
            run_d   = 1'b1;
            state_d = ST_DONE;
          end else begin
            sig_d   = SIG_ZERO;
            req_d   = 1'b1;
            addr_d  = FLASH_ADDR_KEY;
            state_d = ST_READ_KEY;
          end
        end
        ST_READ_KEY: begin
          if (flash_read_valid_in) begin
            sig_d   = flash_read_data_in;
            state_d = ST_KEY;
          end else begin
            req_d = 1'b1;
          end
        end
        ST_KEY: begin
          state_d = ST_SCAN;
          unique case (sig_q)
            KEY_STANDARD:  begin
              uart_en_d = 1'b1;
              can_en_d  = 1'b1;
            end
            KEY_UART_ONLY: begin
              uart_en_d = 1'b1;
              can_en_d  = 1'b0;
            end
            KEY_CAN_ONLY:  begin
              uart_en_d = 1'b0;
              can_en_d  = 1'b1;
            end
            default:       state_d = ST_HANG;
          endcase
        end
        ST_DONE: begin
        end
        ST_HANG: begin
        end
        default: state_d = ST_IN_RESET;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q        <= ST_IN_RESET;
      ext_rst_prev_q <= 1'b1;
      cfg_q          <= CFG_USER;
      mode_q         <= MODE_NONE;
      chan_q         <= CHAN_NONE;
      sig_q          <= SIG_ZERO;
      can_cnt_q      <= CNT_ZERO;
      uart_en_q      <= 1'b0;
      can_en_q       <= 1'b0;
      swrst_q        <= 1'b0;
      run_q          <= 1'b0;
      req_q          <= 1'b0;
      addr_q         <= FLASH_ADDR_SIG_A;
    end else begin
      state_q        <= state_d;
      ext_rst_prev_q <= ext_rst_prev_d;
      cfg_q          <= cfg_d;
      mode_q         <= mode_d;
      chan_q         <= chan_d;
      sig_q          <= sig_d;
      can_cnt_q      <= can_cnt_d;
      uart_en_q      <= uart_en_d;
      can_en_q       <= can_en_d;
      swrst_q        <= swrst_d;
      run_q          <= run_d;
      req_q          <= req_d;
      addr_q         <= addr_d;
    end
  end

  assign boot_mode_out        = mode_q;
  // Code fetches from zero go to test flash in standard bootstrap, and in selective bootstrap until the signature check passes
  assign fetch_test_flash_out = (mode_q == MODE_STANDARD) ||
                                (mode_q == MODE_SELECTIVE && !run_q);
  assign boot_channel_out     = chan_q;
  assign software_reset_out   = swrst_q;
  assign run_user_code_out    = run_q;
  assign boot_hang_out        = (state_q == ST_HANG);
  assign boot_done_out        = (state_q == ST_DONE);
  assign flash_read_req_out   = req_q;
  assign flash_read_addr_out  = addr_q;
endmodule
`default_nettype wire

// [hw/boot_mode_pkg.sv]
// Package with boot mode encodings, key encodings and timing constants
package boot_mode_pkg;
  localparam logic [1:0] CFG_USER      = 2'h3;
  localparam logic [1:0] CFG_STANDARD  = 2'h2;
  localparam logic [1:0] CFG_SELECTIVE = 2'h1;
  localparam logic [1:0] CFG_RESERVED  = 2'h0;

  typedef enum logic [2:0] {
    MODE_NONE      = 3'h0,
    MODE_USER      = 3'h1,
    MODE_STANDARD  = 3'h2,
    MODE_SELECTIVE = 3'h3,
    MODE_RESERVED  = 3'h4
  } boot_mode_t;

  typedef enum logic [1:0] {
    CHAN_NONE = 2'h0,
    CHAN_UART = 2'h1,
    CHAN_CAN  = 2'h2
  } boot_channel_t;

  // Key encodings onto three of the four fallback behaviours; any other key hangs (configurable)
  localparam logic [15:0] KEY_STANDARD  = 16'h0000;
  localparam logic [15:0] KEY_UART_ONLY = 16'h0001;
  localparam logic [15:0] KEY_CAN_ONLY  = 16'h0002;

  // Signature algorithm constants (configurable)
  localparam logic [15:0] SIG_REFERENCE = 16'hA5A5;
  localparam logic [15:0] SIG_ZERO      = 16'h0000;

  localparam logic [1:0]  FLASH_ADDR_SIG_A = 2'h0;
  localparam logic [1:0]  FLASH_ADDR_SIG_B = 2'h1;
  localparam logic [1:0]  FLASH_ADDR_KEY   = 2'h2;

  // Least time a dominant level must hold to count as a valid CAN bit
  localparam int          CAN_BIT_NS     = 1000;
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          CAN_BIT_CYC_I  = (CAN_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  CAN_BIT_CYCLES = CAN_BIT_CYC_I[7:0];
  localparam logic [7:0]  CNT_ZERO       = 8'h00;
  localparam logic [7:0]  CNT_ONE        = 8'h01;
endpackage

// [tb/boot_mode_monitor.sv]
// Assertion checker for the boot mode selector ports
`timescale 1ns/1ps
`default_nettype none
module boot_mode_monitor
  import boot_mode_pkg::*;
(
  input wire logic                    clock_in,
  input wire logic                    rst_in,
  input wire logic                    external_reset_input,
  input wire logic                    uart_receive_line,
  input wire logic                    flash_read_req_out,
  input wire logic [1:0]              flash_read_addr_out,
  input wire logic                    flash_read_valid_in,
  input wire boot_mode_pkg::boot_mode_t    boot_mode_out,
  input wire logic                    fetch_test_flash_out,
  input wire boot_mode_pkg::boot_channel_t boot_channel_out,
  input wire logic                    software_reset_out,
  input wire logic                    run_user_code_out,
  input wire logic                    boot_hang_out,
  input wire logic                    boot_done_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  chk_mode_held: assert property (boot_mode_out != MODE_NONE && external_reset_input
    |=> $stable(boot_mode_out)) else $error("mode changed without reset");
  chk_user_run: assert property ($rose(boot_mode_out == MODE_USER)
    |-> ##[0:2] (run_user_code_out && !fetch_test_flash_out)) else $error("user mode not run");
  chk_std_fetch: assert property (boot_mode_out == MODE_STANDARD
    |-> fetch_test_flash_out) else $error("standard mode not fetching test flash");
  chk_uart_first: assert property ($fell(uart_receive_line) && !boot_done_out
    && boot_mode_out == MODE_STANDARD |-> ##[1:4] boot_channel_out == CHAN_UART)
    else $error("uart start not taken");
  chk_chan_done: assert property (boot_channel_out != CHAN_NONE
    |-> boot_done_out && boot_mode_out inside {MODE_STANDARD, MODE_SELECTIVE})
    else $error("channel outside bootstrap");
  chk_read_hold: assert property (flash_read_req_out && !flash_read_valid_in
    && external_reset_input |=> flash_read_req_out && $stable(flash_read_addr_out))
    else $error("flash read dropped");
  chk_swrst_pulse: assert property (software_reset_out
    |-> ##[0:1] run_user_code_out ##1 !software_reset_out) else $error("bad soft reset");
  chk_sel_swrst: assert property ($rose(run_user_code_out)
    && boot_mode_out == MODE_SELECTIVE |-> software_reset_out)
    else $error("selective pass without soft reset");
  chk_reserved_hang: assert property ($rose(boot_mode_out == MODE_RESERVED)
    |-> ##[0:2] (boot_hang_out && !run_user_code_out)) else $error("reserved not hung");
endmodule
bind boot_mode_selector boot_mode_monitor i_mon (.clock_in, .rst_in, .external_reset_input,
  .uart_receive_line, .flash_read_req_out, .flash_read_addr_out, .flash_read_valid_in,
  .boot_mode_out, .fetch_test_flash_out, .boot_channel_out, .software_reset_out,
  .run_user_code_out, .boot_hang_out, .boot_done_out);
`default_nettype wire

// [tb/flash_host_model.sv]
// Behavioural user flash holding the signature and key words
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  input  wire logic        clock_in,
  input  wire logic        req_in,
  input  wire logic [1:0]  addr_in,
  input  wire logic [15:0] sig_a_in,
  input  wire logic [15:0] sig_b_in,
  input  wire logic [15:0] key_in,
  input  wire logic [31:0] delay_in,
  output var logic         valid_out,
  output var logic [15:0]  data_out
);
  // One process owns both outputs so each has a single driver
  initial begin
    valid_out = 1'b0;
    data_out  = 16'h0000;
    forever begin
      @(posedge clock_in);
      if (req_in) begin
        repeat (delay_in) @(posedge clock_in);
        valid_out <= 1'b1;
        // Words were programmed by the user before this boot
        data_out <= (addr_in == 2'h0) ? sig_a_in : (addr_in == 2'h1) ? sig_b_in : key_in;
        @(posedge clock_in);
        valid_out <= 1'b0;
        data_out <= ~data_out;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the boot mode selector
`timescale 1ns/1ps
`default_nettype none
`define CHECK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module testbench;
  import boot_mode_pkg::*;
  typedef struct packed {boot_mode_t m; boot_channel_t c; logic r; logic h;} note_t;
  logic clock_in = 0, rst_in = 1, ext_in = 1, hi = 1, lo = 1, uart = 1, can = 1;
  logic req, valid, swr, fetch, run, hang, done, seen_q = 0;
  logic [1:0] addr;
  logic [15:0] data, sig_a, sig_b, key;
  boot_mode_t mode;
  boot_channel_t chan;
  note_t q[$], e;
  int num_errors = 0, compares = 0, dly = 1;
  logic [15:0] keys[4] = '{KEY_STANDARD, KEY_UART_ONLY, KEY_CAN_ONLY, 16'h0003};
  boot_channel_t chans[4] = '{CHAN_UART, CHAN_UART, CHAN_CAN, CHAN_NONE};
  int stims[4] = '{1, 6, 3, 0};
  always #25 clock_in = ~clock_in;
  boot_mode_selector i_dut (.clock_in(clock_in), .rst_in(rst_in), .external_reset_input(ext_in),
    .boot_config_bit_high(hi), .boot_config_bit_low(lo), .uart_receive_line(uart),
    .can_receive_line(can), .flash_read_req_out(req), .flash_read_addr_out(addr),
    .flash_read_valid_in(valid), .flash_read_data_in(data), .boot_mode_out(mode),
    .fetch_test_flash_out(fetch), .boot_channel_out(chan), .software_reset_out(swr),
    .run_user_code_out(run), .boot_hang_out(hang), .boot_done_out(done));
  flash_host_model i_flash (.clock_in(clock_in), .req_in(req), .addr_in(addr), .sig_a_in(sig_a),
    .sig_b_in(sig_b), .key_in(key), .delay_in(dly), .valid_out(valid), .data_out(data));
  task end_of_test;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task pulse(input int on_can, input int n);
    if (on_can) can <= 1'b0; else uart <= 1'b0;
    repeat (n) @(posedge clock_in);
    uart <= 1'b1;
    can <= 1'b1;
    @(posedge clock_in);
  endtask
  // Stimulus bits: 0 uart start, 1 dominant CAN bit, 2 uart start after CAN
  task run_case(input logic [1:0] cfg, input int stim, input note_t n);
    int i;
    q.push_back(n);
    @(posedge clock_in);
    ext_in <= 1'b0;
    {hi, lo} <= cfg;
    repeat (4) @(posedge clock_in);
    ext_in <= 1'b1;
    repeat (30) @(posedge clock_in);
    if (stim[0]) pulse(0, 2);
    if (stim[1]) pulse(1, 25);
    if (stim[2]) pulse(0, 2);
    for (i = 0; i < 200 && q.size() > 0; i++) @(posedge clock_in);
    if (q.size() > 0) begin
      num_errors++;
      $display("BAD result exp %0h got none", n);
      q.delete();
    end
    $display("test with config %0h stimulus %0d ends", cfg, stim);
  endtask
  always @(posedge clock_in) begin
    if (!rst_in && (done | hang) && !seen_q) begin
      if (q.size() == 0) begin
        num_errors++;
        $display("BAD result exp none got %0h", mode);
      end else begin
        e = q.pop_front();
        `CHECK("mode", e.m, mode)
        `CHECK("channel", e.c, chan)
        `CHECK("run", e.r, run)
        `CHECK("hang", e.h, hang)
        `CHECK("fetch", (e.m == MODE_STANDARD) | (e.m == MODE_SELECTIVE & !e.r), fetch)
      end
    end
    seen_q <= done | hang;
  end
  initial begin
    repeat (5000) @(posedge clock_in);
    num_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h64631a1f));
    sig_a = 16'($urandom);
    sig_b = sig_a ^ 16'h1234;
    key = KEY_STANDARD;
    keys[3] = 16'h0003 + 16'($urandom % 100);
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    run_case(2'h3, 0, '{MODE_USER, CHAN_NONE, 1'b1, 1'b0});
    run_case(2'h0, 0, '{MODE_RESERVED, CHAN_NONE, 1'b0, 1'b1});
    run_case(2'h2, 1, '{MODE_STANDARD, CHAN_UART, 1'b0, 1'b0});
    run_case(2'h2, 2, '{MODE_STANDARD, CHAN_CAN, 1'b0, 1'b0});
    sig_b = sig_a ^ SIG_REFERENCE;
    run_case(2'h1, 0, '{MODE_SELECTIVE, CHAN_NONE, 1'b1, 1'b0});
    sig_b = ~sig_b;
    for (int k = 0; k < 4; k++) begin
      key = keys[k];
      dly = $urandom % 4;
      run_case(2'h1, stims[k], '{MODE_SELECTIVE, chans[k], 1'b0, k == 3});
    end
    end_of_test();
  end
endmodule
`default_nettype wire
